// *** aos_pkg.sv ***
// Shared constants for the analog output sequencer
package aos_pkg;

    // Core clock and pacing limits
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned RATE_MAX_SPS = 500000;
    // Slowest rate in milli-samples per second (0.75 S/s)
    localparam int unsigned RATE_MIN_MSPS = 750;
    // Shortest pacing period rounds up to whole cycles
    localparam int unsigned PACE_DIV_MIN_CYC = (CLK_HZ + RATE_MAX_SPS - 1) / RATE_MAX_SPS;
    // Longest pacing period rounds down; product needs 64 bits
    localparam longint unsigned PACE_DIV_MAX_L = (64'(CLK_HZ) * 64'd1000) / 64'(RATE_MIN_MSPS);
    localparam int unsigned PACE_DIV_MAX_CYC = 32'(PACE_DIV_MAX_L);

    // Widths
    localparam int DIV_W = 26;
    localparam int BUFLEN_W = 18;
    localparam int BUFQ_W = 8;
    localparam int WORD_W = 16;
    // Converter resolution of this build variant
    localparam int DAC_RES = 16;
    localparam int NUM_DAC = 4;
    localparam int LIST_MAX = 5;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;

    // Channel codes
    localparam logic [2:0] CH_DOUT = 3'h4;
    localparam logic [2:0] LIST_MAX_CODE = 3'h5;

    // Buffers below this size stop after current and next buffer
    localparam logic [BUFLEN_W-1:0] BUF_SMALL_LIM = 18'h20000;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_DIV = 8'h08;
    localparam logic [7:0] OFF_CHLIST = 8'h0C;
    localparam logic [7:0] OFF_BUFLEN = 8'h10;
    localparam logic [7:0] OFF_BUFQ = 8'h14;
    localparam logic [7:0] OFF_DATA = 8'h18;
    localparam logic [7:0] OFF_SINGLE = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;

    // Field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_ORDERLY = 1;
    localparam int CTRL_ABORT = 2;
    localparam int CFG_CLK_EXT = 0;
    localparam int CFG_TRIG_EXT = 1;
    localparam int CFG_TRIG_RISE = 2;
    localparam int CFG_WRAP_LSB = 3;
    localparam int CHLIST_CNT_LSB = 16;
    localparam int BUFQ_DONE_LSB = 8;
    localparam int SV_CHAN_LSB = 16;
    localparam int STS_UF = 0;
    localparam int STS_OS = 1;
    localparam int STS_BD = 2;
    localparam int STS_RUNNING = 3;

    // Wrap mode codes
    localparam logic [1:0] WRAP_NONE = 2'h0;
    localparam logic [1:0] WRAP_MULTI = 2'h1;
    localparam logic [1:0] WRAP_SINGLE = 2'h2;

    // Reset values
    localparam logic [DIV_W-1:0] DIV_RST = 26'h0000032;
    localparam logic [BUFLEN_W-1:0] BUFLEN_RST = 18'h00400;
    localparam logic [14:0] CHLIST_RST = 15'h0000;
    localparam logic [2:0] CHCNT_RST = 3'h1;

    // Sequencer states
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_ARMED = 4'h2,
        S_RUN = 4'h4,
        S_LOAD = 4'h8
    } aos_state_t;

endpackage

// *** aos_fifo.sv ***
`timescale 1ns/100ps
// Output sample FIFO with recirculation for repeating patterns
module aos_fifo
    import aos_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Fill side
    input wire logic push_valid,
    input wire logic [WORD_W-1:0] push_data,
    output logic push_ready,
    // Drain side
    output logic pop_valid,
    input wire logic pop_ready,
    output logic [WORD_W-1:0] pop_data,
    // Control and status
    input wire logic recirc,
    output logic [FIFO_AW:0] level
);

    typedef struct packed {
        logic [FIFO_DEPTH-1:0][WORD_W-1:0] mem; // Sample storage
        logic [FIFO_AW-1:0] wr;                 // Write index
        logic [FIFO_AW-1:0] rd;                 // Read index
        logic [FIFO_AW:0] level;                // Words held
    } aos_fifo_t;

    aos_fifo_t q;
    aos_fifo_t n;
    logic do_push;
    logic do_pop;

    // Host may not fill while words are recirculating: slot use would clash
    assign push_ready = (q.level != (FIFO_AW+1)'(FIFO_DEPTH)) && !recirc;
    assign pop_valid = (q.level != '0);
    assign pop_data = q.mem[q.rd];
    assign level = q.level;
    assign do_push = push_valid && push_ready;
    assign do_pop = pop_ready && pop_valid;

    // Next-state: a recirculating pop writes the word back at the tail
    always_comb
    begin
        n = q;
        if (do_pop)
        begin
            n.rd = q.rd + 1'b1;
            if (recirc)
            begin
                n.mem[q.wr] = q.mem[q.rd]; // R16
                n.wr = q.wr + 1'b1;
            end
        end
        if (do_push)
        begin
            n.mem[q.wr] = push_data;
            n.wr = q.wr + 1'b1;
        end
        n.level = q.level + (FIFO_AW+1)'(do_push) - (FIFO_AW+1)'(do_pop && !recirc);
    end

    // State register
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            q <= '0;
        else
            q <= n;
    end

endmodule

// *** aos_sequencer.sv ***
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
// Functional notes
// (R01) Software trigger: start command starts at once
// (R02) External trigger on chosen edge polarity
// (R03) Internal pacing from 0.75 S/s to 500 kS/s
// (R04) External clock: update on each rising edge
// (R05) Single value updates one channel, unstoppable
// (R06) Interleaved words fill list entries in turn
// (R07) Orderly stop finishes samples, then ignores triggers
// (R08) Abrupt stop halts now, ignores later triggers
// (R09) Host pattern: 2 to per-count maximum samples
// (R10) Host pattern length multiple of channel count
// (R11) Waveform channels share clock, trigger, count
// (R12) Words are offset binary, passed unchanged
// (R13) Buffer done event after each buffer
// (R14) Wrap none: back to back, end when out
// (R15) Wrap multiple: repeat current buffer until stopped
// (R16) Wrap single: recirculate FIFO contents, no reload
// (R17) Small buffers: stop after current plus next
// (R18) Pace on empty FIFO flags underflow, hold outputs
// (R19) Pace during loading flags over-sample
// (R20) Codes 0-3 DACs, 4 port, five entries
// (R21) Resolution fixed per build variant
// (R22) Each pace updates whole list, one word each
// (R23) Error flags sticky until host clears them
module aos_sequencer
    import aos_pkg::*;
#(
    parameter int unsigned PACE_DIV_MAX = PACE_DIV_MAX_CYC
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External pacing clock and trigger
    input wire logic ext_out_clk,
    input wire logic ext_out_trig,
    // Converter and port outputs
    output logic [NUM_DAC-1:0][DAC_RES-1:0] dac_value,
    output logic [WORD_W-1:0] dout_port,
    output logic [LIST_MAX-1:0] chan_update,
    output logic seq_running
);

    typedef struct packed {
        aos_state_t state;                       // Sequencer state
        logic clk_ext;                           // External pacing select
        logic trig_ext;                          // External trigger select
        logic trig_rise;                         // Rising trigger edge
        logic [1:0] wrap;                        // Buffer wrap mode
        logic [DIV_W-1:0] div;                   // Pacing period in cycles
        logic [DIV_W-1:0] pace_cnt;              // Pacing counter
        logic [14:0] chlist;                     // Five 3-bit list entries
        logic [2:0] chcnt;                       // Entries in use
        logic [2:0] idx;                         // Entry being loaded
        logic [BUFLEN_W-1:0] buflen;             // Words per buffer
        logic [BUFLEN_W-1:0] word_cnt;           // Words sent of buffer
        logic [BUFQ_W-1:0] bufq;                 // Buffers not yet finished
        logic [BUFQ_W-1:0] bufs_done;            // Finished buffers, wraps
        logic flag_uf;                           // Underflow
        logic flag_os;                           // Over-sample
        logic flag_bd;                           // Buffer done
        logic stop_pend;                         // Orderly stop requested
        logic [1:0] stop_bufs;                   // Buffers left before halt
        logic trig_prev;                         // Trigger input last cycle
        logic eclk_prev;                         // Pacing input last cycle
        logic [NUM_DAC-1:0][DAC_RES-1:0] dac;    // Converter codes
        logic [WORD_W-1:0] dout;                 // Digital port value
        logic [LIST_MAX-1:0] upd;                // Per-channel update pulse
        logic [31:0] prdata;                     // Read data
        logic pready;                            // Access phase ready
        logic pslverr;                           // Access error
        logic running;                           // Sequence not idle
    } aos_regs_t;

    aos_regs_t q;
    aos_regs_t n;

    // Bus decode
    logic setup;
    logic commit;
    logic wr_commit;
    logic addr_ok;
    logic [31:0] rdata;
    logic start_cmd;
    logic orderly_cmd;
    logic abort_cmd;
    logic sv_wr;
    // Pacing and trigger
    logic active;
    logic int_pace;
    logic pace;
    logic trig_edge;
    // FIFO link
    logic f_push;
    logic f_ready;
    logic f_valid;
    logic f_pop;
    logic [WORD_W-1:0] f_data;
    logic [FIFO_AW:0] f_level;
    logic recirc;
    // Load-step helpers
    logic [2:0] cur_ch;
    logic buf_end;
    logic end_op;

    // Clamp the programmed period into the supported rate span
    function automatic logic [DIV_W-1:0] pace_div(input logic [DIV_W-1:0] d);
        logic [DIV_W-1:0] r;
        r = d;
        if (d < DIV_W'(PACE_DIV_MIN_CYC))
            r = DIV_W'(PACE_DIV_MIN_CYC);
        else if (d > DIV_W'(PACE_DIV_MAX))
            r = DIV_W'(PACE_DIV_MAX);
        return r;
    endfunction

    // Route one word to a channel; unknown codes are dropped
    function automatic aos_regs_t put_word(input aos_regs_t r, input logic [2:0] ch, input logic [WORD_W-1:0] w);
        aos_regs_t o;
        o = r;
        if (ch == CH_DOUT)
        begin
            o.dout = w;
            o.upd[4] = 1'b1;
        end
        else if (ch < CH_DOUT)
        begin
            // Offset binary code goes straight to the converter
            o.dac[ch[1:0]] = w[DAC_RES-1:0]; // R12 R21
            o.upd[ch] = 1'b1;
        end
        return o;
    endfunction

    // Channel code of a list entry
    function automatic logic [2:0] entry(input logic [14:0] list, input logic [2:0] i);
        return list[3*i +: 3];
    endfunction

    // APB phase decode; pready rises one cycle after setup
    assign setup = psel && !penable;
    assign commit = psel && penable && q.pready;
    assign wr_commit = commit && pwrite;
    assign start_cmd = wr_commit && (paddr == OFF_CTRL) && pwdata[CTRL_START];
    assign orderly_cmd = wr_commit && (paddr == OFF_CTRL) && pwdata[CTRL_ORDERLY];
    assign abort_cmd = wr_commit && (paddr == OFF_CTRL) && pwdata[CTRL_ABORT];
    assign sv_wr = wr_commit && (paddr == OFF_SINGLE);
    assign f_push = wr_commit && (paddr == OFF_DATA) && !q.pslverr;

    // One clock and one trigger serve every listed channel
    assign active = (q.state == S_RUN) || (q.state == S_LOAD); // R11
    assign int_pace = (q.pace_cnt >= pace_div(q.div) - 1'b1); // R03
    assign pace = active && (q.clk_ext ? (ext_out_clk && !q.eclk_prev) : int_pace); // R04
    assign trig_edge = q.trig_rise ? (ext_out_trig && !q.trig_prev) : (!ext_out_trig && q.trig_prev); // R02

    // Recirculate for single wrap, and for multiple wrap on the last buffer
    assign recirc = (q.wrap == WRAP_SINGLE) || ((q.wrap == WRAP_MULTI) && (q.bufq <= 8'h01)); // R15 R16
    assign cur_ch = entry(q.chlist, q.idx);
    assign buf_end = (BUFLEN_W'(q.word_cnt + 1'b1) == q.buflen);
    assign end_op = (q.stop_pend && (q.stop_bufs == 2'h1)) || ((q.wrap == WRAP_NONE) && (q.bufq <= 8'h01));
    assign f_pop = (q.state == S_LOAD) && f_valid && !abort_cmd;

    // Read data and address check
    always_comb
    begin
        rdata = 32'h0;
        addr_ok = 1'b1;
        unique case (paddr)
            OFF_CTRL: rdata = {28'h0, q.state};
            OFF_CFG: rdata = {27'h0, q.wrap, q.trig_rise, q.trig_ext, q.clk_ext};
            OFF_DIV: rdata = {6'h0, q.div};
            OFF_CHLIST: rdata = {13'h0, q.chcnt, 1'b0, q.chlist};
            OFF_BUFLEN: rdata = {14'h0, q.buflen};
            OFF_BUFQ: rdata = {16'h0, q.bufs_done, q.bufq};
            OFF_DATA: rdata = {27'h0, f_level};
            OFF_SINGLE: rdata = 32'h0;
            OFF_STATUS: rdata = {28'h0, active, q.flag_bd, q.flag_os, q.flag_uf};
            default: addr_ok = 1'b0;
        endcase
    end

    // Output FIFO between the host and the converters
    aos_fifo u_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .push_valid(f_push),
        .push_data(pwdata[WORD_W-1:0]),
        .push_ready(f_ready),
        .pop_valid(f_valid),
        .pop_ready(f_pop),
        .pop_data(f_data),
        .recirc(recirc),
        .level(f_level)
    );

    // Next-state of bus, configuration and sequencer
    always_comb
    begin
        n = q;
        n.upd = '0;
        n.trig_prev = ext_out_trig;
        n.eclk_prev = ext_out_clk;

        // Bus answer: ready in the access phase, error on bad address or on a data write while the FIFO is full or recirculating
        if (setup)
        begin
            n.pready = 1'b1;
            n.prdata = rdata;
            n.pslverr = !addr_ok || (pwrite && (paddr == OFF_DATA) && !f_ready);
        end
        else if (commit)
        begin
            n.pready = 1'b0;
            n.pslverr = 1'b0;
        end

        // Configuration writes
        if (wr_commit && !q.pslverr)
        begin
            unique case (paddr)
                OFF_CFG:
                begin
                    n.clk_ext = pwdata[CFG_CLK_EXT];
                    n.trig_ext = pwdata[CFG_TRIG_EXT];
                    n.trig_rise = pwdata[CFG_TRIG_RISE];
                    n.wrap = pwdata[CFG_WRAP_LSB +: 2];
                end
                OFF_DIV: n.div = pwdata[DIV_W-1:0];
                OFF_CHLIST:
                begin
                    n.chlist = pwdata[14:0];
                    // More than five entries is clipped to five
                    n.chcnt = (pwdata[CHLIST_CNT_LSB +: 3] > LIST_MAX_CODE) ? LIST_MAX_CODE
                        : pwdata[CHLIST_CNT_LSB +: 3]; // R20
                end
                OFF_BUFLEN: n.buflen = pwdata[BUFLEN_W-1:0];
                OFF_BUFQ: n.bufq = (q.bufq == 8'hFF) ? q.bufq : q.bufq + 1'b1;
                OFF_STATUS:
                begin
                    // Write one to clear; a same-cycle set below still wins
                    if (pwdata[STS_UF])
                        n.flag_uf = 1'b0;
                    if (pwdata[STS_OS])
                        n.flag_os = 1'b0;
                    if (pwdata[STS_BD])
                        n.flag_bd = 1'b0;
                end
                default:
                begin
                end
            endcase
        end

        // Internal pacing counter only runs while the sequence runs
        if (active && !q.clk_ext)
            n.pace_cnt = int_pace ? '0 : q.pace_cnt + 1'b1;
        else
            n.pace_cnt = '0;

        // Orderly stop: small buffers run the current and the next one
        if (orderly_cmd && active && !q.stop_pend)
        begin
            n.stop_pend = 1'b1;
            n.stop_bufs = (q.buflen < BUF_SMALL_LIM) ? 2'h2 : 2'h1; // R07 R17
        end

        // Sequencer
        unique case (q.state)
            S_IDLE:
            begin
                // Triggers are not watched here, so stopped runs ignore them
                if (start_cmd)
                begin
                    n.word_cnt = '0;
                    n.stop_pend = 1'b0;
                    n.idx = 3'h0;
                    n.state = q.trig_ext ? S_ARMED : S_RUN; // R01
                end
            end
            S_ARMED:
            begin
                if (abort_cmd || orderly_cmd)
                    n.state = S_IDLE; // R08
                else if (trig_edge)
                    n.state = S_RUN; // R02
            end
            S_RUN:
            begin
                if (abort_cmd)
                    n.state = S_IDLE; // R08
                else if (pace && (q.chcnt != 3'h0))
                begin
                    if (!f_valid)
                        n.flag_uf = 1'b1; // R18 R23
                    else
                    begin
                        n.idx = 3'h0;
                        n.state = S_LOAD; // R22
                    end
                end
            end
            S_LOAD:
            begin
                if (abort_cmd)
                    n.state = S_IDLE; // R08
                else
                begin
                    if (pace)
                        n.flag_os = 1'b1; // R19 R23
                    if (!f_valid)
                    begin
                        // Ran dry mid-list: the rest keep their last codes
                        n.flag_uf = 1'b1; // R18
                        n.state = S_RUN;
                    end
                    else
                    begin
                        n = put_word(n, cur_ch, f_data); // R06
                        n.word_cnt = BUFLEN_W'(q.word_cnt + 1'b1);
                        if (buf_end)
                        begin
                            n.word_cnt = '0;
                            n.flag_bd = 1'b1; // R13
                            n.bufs_done = q.bufs_done + 1'b1;
                            if (q.bufq != 8'h00)
                                n.bufq = n.bufq - 1'b1;
                            if (q.stop_pend)
                                n.stop_bufs = q.stop_bufs - 1'b1;
                        end
                        if (buf_end && end_op)
                            n.state = S_IDLE; // R07 R14 R17
                        else if (q.idx == q.chcnt - 1'b1)
                            n.state = S_RUN; // R22
                        else
                            n.idx = q.idx + 1'b1;
                    end
                end
            end
        endcase
        n.running = (n.state != S_IDLE);

        // Single value goes out immediately and no stop touches it
        if (sv_wr)
            n = put_word(n, pwdata[SV_CHAN_LSB +: 3], pwdata[WORD_W-1:0]); // R05
    end

    // State register
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            q <= '0;
            q.state <= S_IDLE;
            q.div <= DIV_RST;
            q.chlist <= CHLIST_RST;
            q.chcnt <= CHCNT_RST;
            q.buflen <= BUFLEN_RST;
        end
        else
            q <= n;
    end

    // Outputs straight from the state register
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign dac_value = q.dac;
    assign dout_port = q.dout;
    assign chan_update = q.upd;
    assign seq_running = q.running;

    // Software trigger starts without waiting
    sw_start_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R01
        (q.state == S_IDLE && start_cmd && !q.trig_ext) |=> (q.state == S_RUN))
        else $error("software start did not run");

    // External trigger edge moves armed to run
    ext_trig_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R02
        (q.state == S_ARMED && trig_edge && !abort_cmd && !orderly_cmd) |=> (q.state == S_RUN))
        else $error("trigger edge ignored while armed");

    // Idle never starts running without a start command
    idle_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R07
        (q.state == S_IDLE && !start_cmd) |=> (q.state == S_IDLE))
        else $error("left idle without start");

    // Abrupt stop ends any active sequence in one cycle
    abort_stop_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R08
        (abort_cmd && q.state != S_IDLE) |=> (q.state == S_IDLE && $stable(q.dac)))
        else $error("abrupt stop did not halt");

    // Single value for code 0 reaches converter 0 next cycle
    single_value_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R05
        (sv_wr && pwdata[SV_CHAN_LSB +: 3] == 3'h0) |=> (dac_value[0] == $past(pwdata[DAC_RES-1:0]) && chan_update[0]))
        else $error("single value not applied");

    // Pace on empty FIFO raises underflow and holds codes
    underflow_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R18
        (q.state == S_RUN && pace && q.chcnt != 3'h0 && !f_valid && !abort_cmd && !sv_wr)
        |=> (q.flag_uf && $stable(dac_value) && $stable(dout_port)))
        else $error("underflow not flagged");

    // Pace during loading raises over-sample
    oversample_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R19
        (q.state == S_LOAD && pace && !abort_cmd) |=> q.flag_os)
        else $error("over-sample not flagged");

    // A full list of five loads in five cycles then returns to run
    list_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R22
        (q.state == S_RUN && $past(q.state) == S_LOAD && q.chcnt == 3'h5 && q.idx == 3'h4 && !q.flag_uf)
        |-> ($past(q.state, 5) == S_LOAD && $past(q.idx, 5) == 3'h0))
        else $error("list not loaded one word per entry");

    // Error flag stays until cleared by the host
    sticky_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R23
        (q.flag_os && !(wr_commit && paddr == OFF_STATUS && pwdata[STS_OS])) |=> q.flag_os)
        else $error("over-sample flag dropped");

endmodule

// *** aos_host.sv ***
`timescale 1ns/100ps
// Host side: one APB transfer per bench request
module aos_host
    import aos_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Bench request and result
    input wire logic req,
    input wire logic req_wr,
    input wire logic [7:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic done,
    output logic [31:0] rdata,
    output logic err,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Setup, access until pready, then release; idle lines scramble
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b0;
        end
        else if (psel && penable && pready)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            done <= 1'b1;
            rdata <= prdata;
            err <= pslverr;
        end
        else if (psel)
            penable <= 1'b1;
        else
        begin
            // Done blocks a repeat of the request just served
            done <= 1'b0;
            psel <= req && !done;
            pwrite <= req_wr;
            paddr <= req && !done ? req_addr : ~paddr;
            pwdata <= req && !done ? req_wdata : ~pwdata;
        end
    end
endmodule

// *** analog_output_sequencer_tb.sv ***
`timescale 1ns/100ps
module analog_output_sequencer_tb
    import aos_pkg::*;
;
    logic ref_clk, reset_n, req, req_wr, done, err, psel, penable, pwrite, pready, pslverr;
    logic ext_out_clk, ext_out_trig, seq_running;
    logic [7:0] req_addr, paddr;
    logic [31:0] req_wdata, rdata, pwdata, prdata, v;
    logic [NUM_DAC-1:0][DAC_RES-1:0] dac_value;
    logic [WORD_W-1:0] dout_port;
    logic [LIST_MAX-1:0] chan_update;
    int error_cnt, n_compared, cyc;
    int exp_ch[$];
    logic [15:0] exp_w[$];
    aos_sequencer #(.PACE_DIV_MAX(200)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_out_clk(ext_out_clk), .ext_out_trig(ext_out_trig),
        .dac_value(dac_value), .dout_port(dout_port), .chan_update(chan_update), .seq_running(seq_running));
    aos_host host (.ref_clk(ref_clk), .reset_n(reset_n), .req(req), .req_wr(req_wr), .req_addr(req_addr),
        .req_wdata(req_wdata), .done(done), .rdata(rdata), .err(err), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    task wrap_up;
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            error_cnt++;
            $display("Error at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask
    // One transfer; an edge first so req is never set twice in a step
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= 1'b1;
        req_wr <= w;
        req_addr <= a;
        req_wdata <= d;
        do @(posedge ref_clk); while (done !== 1'b1);
        req <= 1'b0;
    endtask
    // Queue a word for a channel, then push it through DATA or SINGLE
    task put(input int ch, input logic [7:0] a);
        v = $urandom;
        exp_ch.push_back(ch);
        exp_w.push_back(v[15:0]);
        bus(1'b1, a, {13'h0, 3'(ch), v[15:0]});
    endtask
    task pace;
        for (int k = 0; k < 11; k++)
        begin
            @(posedge ref_clk);
            ext_out_clk <= k == 0 || k == 2;
        end
    endtask
    // Reference model: every update must match the next queued word
    always @(posedge ref_clk)
        if (reset_n && chan_update !== 5'h00)
        begin
            chk({exp_ch.size() > 0, chan_update}, {1'b1, 5'h01 << exp_ch[0]});
            chk(chan_update[4] ? dout_port : dac_value[exp_ch[0]], exp_w[0]);
            void'(exp_ch.pop_front());
            void'(exp_w.pop_front());
        end
    // Hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            error_cnt++;
            wrap_up;
        end
    end
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial
    begin
        {reset_n, req, req_wr, req_addr, req_wdata, ext_out_clk, ext_out_trig} = '0;
        void'($urandom(18810));
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        bus(1'b0, OFF_DIV, 0);
        chk(rdata, 50);
        bus(1'b0, 8'h3C, 0);
        chk({err, rdata[30:0]}, 32'h8000_0000);
        for (int k = 0; k < 5; k++)
            put(k, OFF_SINGLE);
        // Two-entry list DAC0 then port, one buffer of four words
        bus(1'b1, OFF_CHLIST, 32'h0002_0020);
        bus(1'b1, OFF_BUFLEN, 4);
        bus(1'b1, OFF_BUFQ, 0);
        for (int i = 0; i < 4; i++)
            put(i % 2 * 4, OFF_DATA);
        bus(1'b1, OFF_CTRL, 1);
        for (int w = 0; w < 600 && seq_running === 1'b1; w++)
            @(posedge ref_clk);
        @(posedge ref_clk);
        chk(exp_w.size(), 0);
        bus(1'b0, OFF_STATUS, 0);
        chk(rdata, 32'h4);
        // Buffer length 0 (2^18 words) with two words: second pace finds FIFO empty
        bus(1'b1, OFF_STATUS, 7);
        bus(1'b1, OFF_BUFLEN, 0);
        bus(1'b1, OFF_BUFQ, 0);
        put(0, OFF_DATA);
        put(4, OFF_DATA);
        bus(1'b1, OFF_CTRL, 1);
        repeat (170) @(posedge ref_clk);
        bus(1'b0, OFF_STATUS, 0);
        chk(rdata, 32'h9);
        bus(1'b1, OFF_CTRL, 4);
        @(posedge ref_clk);
        chk(seq_running, 0);
        bus(1'b0, OFF_STATUS, 0);
        chk(rdata, 32'h1);
        // External rising trigger and external pacing clock
        bus(1'b1, OFF_CFG, 7);
        put(0, OFF_DATA);
        put(4, OFF_DATA);
        bus(1'b1, OFF_CTRL, 1);
        pace;
        bus(1'b0, OFF_CTRL, 0);
        chk(rdata, 2);
        ext_out_trig <= 1'b1;
        repeat (3) @(posedge ref_clk);
        bus(1'b0, OFF_CTRL, 0);
        chk(rdata, 4);
        pace;
        chk(exp_w.size(), 0);
        bus(1'b1, OFF_CTRL, 4);
        ext_out_trig <= 1'b0;
        pace;
        ext_out_trig <= 1'b1;
        pace;
        bus(1'b0, OFF_CTRL, 0);
        chk(rdata, 1);
        bus(1'b0, OFF_STATUS, 0);
        chk(rdata, 32'h3);
        wrap_up;
    end
endmodule
